// File: include/dbx_params.svh
// Reset values and option defaults for the debug exception unit
`ifndef DBX_PARAMS_SVH
`define DBX_PARAMS_SVH

// =====================================================================
// Reset values
`define DBX_RESUME_RST    1'b0
`define DBX_PULSE_RST     1'b0

// =====================================================================
// Option defaults
`define DBX_HW_RF_DEFAULT 1'b0

`endif

// File: include/dbx_pkg.sv
// Types shared by the debug exception unit
package dbx_pkg;

    // =================================================================
    // Decode facts about the instruction now starting
    typedef struct packed {
        logic opBpHit;     // Code breakpoint matches the opcode byte
        logic prefixBpHit; // Code breakpoint matches a prefix byte
        logic isIo;        // Port input or output instruction
        logic isHalt;      // Halt instruction
    } dbx_instr_type;

    // =================================================================
    // One iteration of a repeated string transfer
    typedef struct packed {
        logic iter;        // Iteration finished this cycle
        logic match;       // Its memory access hit a data breakpoint
        logic isInput;     // String input (else string output)
    } dbx_str_type;

    // =================================================================
    // Whole state of the unit, outputs included
    typedef struct packed {
        logic resumeFlag;  // Live resume flag
        logic stackedRf;   // Resume bit pushed at last handler entry
        logic bpSeen;      // Current instruction matched a code break
        logic insPend;     // String input trap owed one iteration
        logic bpFault;     // Instruction breakpoint fault pulse
        logic dataTrap;    // Data breakpoint trap pulse
        logic execGo;      // Instruction may execute pulse
        logic haltEnter;   // Halt state may be entered pulse
    } dbx_state_type;

endpackage : dbx_pkg

// File: hdl/dbx_debug_unit.sv
// Debug breakpoint fault and trap sequencing for the processor core
// Function
// - Prefix-byte code breakpoints need not fault
// - Armed breakpoint, clear flag: fault repeats forever
// - Coinciding fault yields one spurious breakpoint repeat
// - Hardware may set stacked flag on entry
// - String output traps right after matching iteration
// - String input traps one iteration later
// - Code break on port instruction precedes execution
// - Restarted port instruction after resume breaks again
// - Halt breakpoint taken again after resume
`timescale 1ns/1ps
`include "dbx_params.svh"

module dbx_debug_unit #(
    parameter logic HW_RF_ON_FAULT = `DBX_HW_RF_DEFAULT
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst,
    // Instruction boundary from the pipeline
    input  wire logic            instrStart,
    input  wire dbx_pkg::dbx_instr_type instrInfo,
    input  wire logic            instrDone,
    // Handler entry and return
    input  wire logic            otherFault,
    input  wire logic            handlerReturn,
    input  wire logic            returnResumeFlag,
    // Resume from system management mode to the same instruction
    input  wire logic            smiResume,
    input  wire logic            ioRestartEn,
    // Repeated string transfers
    input  wire dbx_pkg::dbx_str_type strInfo,
    // Results, all registered
    output logic                 bpFault,
    output logic                 dataTrap,
    output logic                 execGo,
    output logic                 haltEnter,
    output logic                 resumeFlag,
    output logic                 stackedResumeFlag
);

    // =================================================================
    // State register and its next value
    dbx_pkg::dbx_state_type st_r;   // Registered state
    dbx_pkg::dbx_state_type st_nxt; // Next state
    logic                   takeBp; // Code breakpoint fires now

    // =================================================================
    // Next-state logic
    always_comb begin
        st_nxt           = st_r;
        st_nxt.bpFault   = 1'b0;
        st_nxt.dataTrap  = 1'b0;
        st_nxt.execGo    = 1'b0;
        st_nxt.haltEnter = 1'b0;
        // Only the opcode byte counts; a prefix match is ignored
        // on purpose so behaviour never depends on prefix decode
        takeBp = instrStart && instrInfo.opBpHit
            && !st_r.resumeFlag;
        if (instrStart) begin
            st_nxt.bpSeen = instrInfo.opBpHit;
            if (takeBp) begin
                // Fault before any port access or halt entry
                st_nxt.bpFault    = 1'b1;
                st_nxt.stackedRf  = 1'b0;
                st_nxt.resumeFlag = 1'b0;
            end else begin
                st_nxt.execGo    = 1'b1;
                st_nxt.haltEnter = instrInfo.isHalt;
            end
        end
        // Another fault: the flag is cleared so the breakpoint
        // repeats once on return unless that handler sets it
        if (otherFault) begin
            st_nxt.stackedRf  = st_r.resumeFlag |
                (HW_RF_ON_FAULT & !st_r.bpSeen);
            st_nxt.resumeFlag = 1'b0;
        end
        // Return loads the flag from the restored image
        if (handlerReturn) begin
            st_nxt.resumeFlag = returnResumeFlag;
        end
        // Successful completion uses up the suppression
        if (instrDone && !otherFault) begin
            st_nxt.resumeFlag = 1'b0;
        end
        // Resume to restart a port or halt instruction re-arms it
        if (smiResume && (ioRestartEn || st_r.bpSeen)) begin
            st_nxt.resumeFlag = 1'b0;
        end
        // String transfers: output traps at once, input one late
        if (strInfo.iter) begin
            if (st_r.insPend) begin
                st_nxt.dataTrap = 1'b1;
                st_nxt.insPend  = 1'b0;
            end
            if (strInfo.match && !strInfo.isInput) begin
                st_nxt.dataTrap = 1'b1;
            end
            if (strInfo.match && strInfo.isInput) begin
                st_nxt.insPend = 1'b1;
            end
        end else if (instrDone && st_r.insPend) begin
            // No further iteration: owed trap falls at completion
            st_nxt.dataTrap = 1'b1;
            st_nxt.insPend  = 1'b0;
        end
    end

    // =================================================================
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r.resumeFlag <= `DBX_RESUME_RST;
            st_r.stackedRf  <= `DBX_RESUME_RST;
            st_r.bpSeen     <= `DBX_PULSE_RST;
            st_r.insPend    <= `DBX_PULSE_RST;
            st_r.bpFault    <= `DBX_PULSE_RST;
            st_r.dataTrap   <= `DBX_PULSE_RST;
            st_r.execGo     <= `DBX_PULSE_RST;
            st_r.haltEnter  <= `DBX_PULSE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =================================================================
    // Outputs straight from the state flops
    assign bpFault           = st_r.bpFault;
    assign dataTrap          = st_r.dataTrap;
    assign execGo            = st_r.execGo;
    assign haltEnter         = st_r.haltEnter;
    assign resumeFlag        = st_r.resumeFlag;
    assign stackedResumeFlag = st_r.stackedRf;

    // =================================================================
    // Assertions
    sequence s_prefixOnly;
        instrStart && instrInfo.prefixBpHit && !instrInfo.opBpHit;
    endsequence

    sequence s_armedStart;
        instrStart && instrInfo.opBpHit && !resumeFlag;
    endsequence

    sequence s_insMatch;
        strInfo.iter && strInfo.match && strInfo.isInput && !st_r.insPend;
    endsequence

    property p_prefixIgnored;
        @(posedge clk) disable iff (rst)
        s_prefixOnly |=> !bpFault && execGo;
    endproperty
    a_prefixIgnored: assert property (p_prefixIgnored)
        else $error("prefix breakpoint raised a fault");

    property p_repeatFault;
        @(posedge clk) disable iff (rst)
        s_armedStart |=> bpFault && !resumeFlag;
    endproperty
    a_repeatFault: assert property (p_repeatFault)
        else $error("armed breakpoint did not fault");

    property p_spurious;
        @(posedge clk) disable iff (rst)
        (otherFault && !handlerReturn && !smiResume) ##1
        (instrStart && instrInfo.opBpHit && !handlerReturn[*1])
        |=> bpFault;
    endproperty
    a_spurious: assert property (p_spurious)
        else $error("no repeat after coinciding fault");

    property p_hwStackRf;
        @(posedge clk) disable iff (rst)
        otherFault && resumeFlag |=> stackedResumeFlag;
    endproperty
    a_hwStackRf: assert property (p_hwStackRf)
        else $error("set flag lost on handler entry");

    property p_outsTrap;
        @(posedge clk) disable iff (rst)
        strInfo.iter && strInfo.match && !strInfo.isInput |=> dataTrap;
    endproperty
    a_outsTrap: assert property (p_outsTrap)
        else $error("string output trap not immediate");

    property p_insLate;
        @(posedge clk) disable iff (rst)
        s_insMatch ##1 (!strInfo.iter && !instrDone)[*1] ##1 strInfo.iter
        |=> dataTrap;
    endproperty
    a_insLate: assert property (p_insLate)
        else $error("string input trap not one iteration late");

    property p_insNotEarly;
        @(posedge clk) disable iff (rst)
        s_insMatch |=> !dataTrap;
    endproperty
    a_insNotEarly: assert property (p_insNotEarly)
        else $error("string input trap came too early");

    property p_ioBefore;
        @(posedge clk) disable iff (rst)
        s_armedStart and instrInfo.isIo |=> bpFault && !execGo;
    endproperty
    a_ioBefore: assert property (p_ioBefore)
        else $error("port instruction ran before breakpoint");

    property p_smiRearm;
        @(posedge clk) disable iff (rst)
        smiResume && ioRestartEn && !handlerReturn
        |=> !resumeFlag;
    endproperty
    a_smiRearm: assert property (p_smiRearm)
        else $error("restart resume left breakpoint suppressed");

    property p_haltBefore;
        @(posedge clk) disable iff (rst)
        s_armedStart and instrInfo.isHalt |=> bpFault && !haltEnter;
    endproperty
    a_haltBefore: assert property (p_haltBefore)
        else $error("halt entered before breakpoint");

    property p_rfSuppress;
        @(posedge clk) disable iff (rst)
        instrStart && resumeFlag |=> !bpFault;
    endproperty
    a_rfSuppress: assert property (p_rfSuppress)
        else $error("breakpoint fired with resume flag set");

    property p_rfClear;
        @(posedge clk) disable iff (rst)
        instrDone && !otherFault && !handlerReturn |=> !resumeFlag;
    endproperty
    a_rfClear: assert property (p_rfClear)
        else $error("resume flag survived completion");

endmodule : dbx_debug_unit

// File: tb/dbx_debug_unit_tb.sv
// Self-checking testbench for the debug breakpoint exception unit
`timescale 1ns/1ps

module dbx_debug_unit_tb;

    // ================================================================
    // Signals
    typedef struct packed {
        logic       rf;   // Resume bit restored by the handler
        logic [3:0] info; // opBpHit, prefixBpHit, isIo, isHalt
        logic [5:0] exp;  // Expected outputs after the start
    } dbx_row_type;

    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   instrStart = 1'b0;
    dbx_pkg::dbx_instr_type instrInfo = '0;
    logic                   instrDone = 1'b0;
    logic                   otherFault = 1'b0;
    logic                   handlerReturn = 1'b0;
    logic                   returnResumeFlag = 1'b0;
    logic                   smiResume = 1'b0;
    logic                   ioRestartEn = 1'b0;
    dbx_pkg::dbx_str_type   strInfo = '0;
    logic                   bpFault;
    logic                   dataTrap;
    logic                   execGo;
    logic                   haltEnter;
    logic                   resumeFlag;
    logic                   stackedResumeFlag;
    int                     err_total = 0;
    int                     total_checks = 0;
    wire logic [5:0] string_output_instr = {bpFault, dataTrap, execGo, haltEnter,
                             resumeFlag, stackedResumeFlag};

    // Ordinary starts: each row restores the flag, then starts one
    dbx_row_type rows [8] = '{
        '{1'b0, 4'h8, 6'h20}, '{1'b0, 4'h8, 6'h20},
        '{1'b0, 4'h4, 6'h08}, '{1'b1, 4'h8, 6'h0A},
        '{1'b0, 4'hA, 6'h20}, '{1'b0, 4'h1, 6'h0C},
        '{1'b0, 4'h9, 6'h20}, '{1'b1, 4'h9, 6'h0E}};

    // ================================================================
    // Clock and design
    always #5 clk = ~clk;

    dbx_debug_unit #(.HW_RF_ON_FAULT(1'b0)) i_dut (
        .clk(clk), .rst(rst), .instrStart(instrStart),
        .instrInfo(instrInfo), .instrDone(instrDone),
        .otherFault(otherFault), .handlerReturn(handlerReturn),
        .returnResumeFlag(returnResumeFlag), .smiResume(smiResume),
        .ioRestartEn(ioRestartEn), .strInfo(strInfo),
        .bpFault(bpFault), .dataTrap(dataTrap), .execGo(execGo),
        .haltEnter(haltEnter), .resumeFlag(resumeFlag),
        .stackedResumeFlag(stackedResumeFlag));

    // ================================================================
    // Tasks
    task automatic chk(input logic [5:0] seen, input logic [5:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t outputs %b expected %b", $time, seen, exp);
        end
    endtask : chk

    // Let one edge take the inputs, then drop every raised pulse;
    // only raised ones are touched, so a caller may raise another
    // pulse in the same step without a double assignment
    task automatic go();
        @(negedge clk);
        if (instrStart) begin
            instrStart = 1'b0;
        end
        if (instrDone) begin
            instrDone = 1'b0;
        end
        if (otherFault) begin
            otherFault = 1'b0;
        end
        if (handlerReturn) begin
            handlerReturn = 1'b0;
        end
        if (smiResume) begin
            smiResume = 1'b0;
        end
        if (strInfo != '0) begin
            strInfo = '0;
        end
    endtask : go

    // Handler returns with a chosen flag, then one instruction starts
    task automatic run_instr(input logic rf, input logic [3:0] info,
                             input logic [5:0] exp);
        handlerReturn    = 1'b1;
        returnResumeFlag = rf;
        go();
        chk({5'h00, resumeFlag}, {5'h00, rf});
        instrStart = 1'b1;
        instrInfo  = dbx_pkg::dbx_instr_type'(info);
        go();
        chk(string_output_instr, exp);
    endtask : run_instr

    task automatic tally_and_finish();
        if (err_total == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // ================================================================
    // Main sequence
    initial begin
        // A start held during reset must leave no trace
        instrStart = 1'b1;
        instrInfo  = dbx_pkg::dbx_instr_type'(4'h8);
        repeat (20) @(negedge clk);
        chk(string_output_instr, 6'h00);
        rst        = 1'b0;
        instrStart = 1'b0;
        go();
        chk(string_output_instr, 6'h00);
        foreach (rows[i]) run_instr(rows[i].rf, rows[i].info, rows[i].exp);
        // Coinciding fault clears the flag, so the break repeats once
        handlerReturn    = 1'b1;
        returnResumeFlag = 1'b1;
        go();
        otherFault = 1'b1;
        go();
        chk(string_output_instr, 6'h01);
        run_instr(1'b0, 4'h8, 6'h20);
        // A completed instruction consumes the flag
        run_instr(1'b1, 4'h8, 6'h0A);
        instrDone = 1'b1;
        go();
        chk(string_output_instr, 6'h00);
        // Other handler sets the flag too: no spurious repeat
        otherFault = 1'b1;
        go();
        run_instr(1'b1, 4'h8, 6'h0A);
        // Port restart and halt resume both break again
        for (int k = 0; k < 2; k++) begin
            run_instr(1'b1, k ? 4'h9 : 4'hA, k ? 6'h0E : 6'h0A);
            smiResume   = 1'b1;
            ioRestartEn = !k;
            go();
            chk(string_output_instr, 6'h00);
            run_instr(1'b0, k ? 4'h9 : 4'hA, 6'h20);
        end
        // Output match traps at once, input match one iteration late
        strInfo = dbx_pkg::dbx_str_type'(3'b110);
        @(negedge clk);
        chk(string_output_instr, 6'h10);
        strInfo = dbx_pkg::dbx_str_type'(3'b111);
        @(negedge clk);
        chk(string_output_instr, 6'h00);
        strInfo = '0;
        @(negedge clk);
        chk(string_output_instr, 6'h00);
        strInfo = dbx_pkg::dbx_str_type'(3'b100);
        @(negedge clk);
        chk(string_output_instr, 6'h10);
        // Last iteration matches: the owed trap falls at completion
        strInfo = dbx_pkg::dbx_str_type'(3'b111);
        @(negedge clk);
        chk(string_output_instr, 6'h00);
        strInfo   = '0;
        instrDone = 1'b1;
        go();
        chk(string_output_instr, 6'h10);
        tally_and_finish();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        #50000;
        err_total++;
        tally_and_finish();
    end

endmodule : dbx_debug_unit_tb
